// ==== shared/pbhh_pkg.sv ====
// constants and types shared by the primary bus release logic
// assumes one clock at 20 MHz from which the phase-one clock is derived
package pbhh_pkg;

  localparam int unsigned PBHH_CLK_PERIOD_NS = 50;
  // phase-one clock: high and low halves each last this many clock cycles
  localparam int unsigned PBHH_PHASE_HALF_CYC = 1;
  localparam int unsigned PBHH_SYNC_STAGES    = 2;
  localparam int unsigned PBHH_ADDR_W         = 24;
  localparam int unsigned PBHH_DATA_W         = 32;

  localparam logic PBHH_GRANT_RST  = 1'b1;
  localparam logic PBHH_STROBE_RST = 1'b1;
  localparam logic PBHH_REQ_RST    = 1'b1;
  localparam logic PBHH_PHASE_RST  = 1'b0;
  localparam logic PBHH_DRIVE_RST  = 1'b1;

  // gray order along own -> quiet -> held -> leave -> own
  typedef enum logic [1:0] {
    PBHH_ST_OWN   = 2'b00,
    PBHH_ST_QUIET = 2'b01,
    PBHH_ST_HELD  = 2'b11,
    PBHH_ST_LEAVE = 2'b10
  } pbhh_state_t;

endpackage

// ==== shared/pbhh_wr_if.sv ====
// carrier between the bus owner and its one-entry posted write store
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface pbhh_wr_if #(
  parameter int unsigned AW = 24,
  parameter int unsigned DW = 32
);
  logic          push_valid;
  logic          push_ready;
  logic [AW-1:0] push_addr;
  logic [DW-1:0] push_data;
  logic          pend;
  logic [AW-1:0] pend_addr;
  logic [DW-1:0] pend_data;
  logic          pop;

  modport fill  (output push_valid, push_addr, push_data, pop, input push_ready, pend, pend_addr, pend_data);
  modport store (input push_valid, push_addr, push_data, pop, output push_ready, pend, pend_addr, pend_data);
endinterface
`default_nettype wire

// ==== src/pbhh_sync.sv ====
// level synchroniser for the asynchronous release request
// assumes the input may change anywhere within a clock period
`timescale 1ns/1ns
`default_nettype none
module pbhh_sync
  import pbhh_pkg::*;
#(
  parameter int unsigned STAGES = PBHH_SYNC_STAGES
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  initial
  begin
    if (STAGES < 2)
      $error("pbhh_sync needs at least two stages");
  end

  logic [STAGES-1:0] chain;

  // reset to the idle level; a request held across reset reaches sync_o STAGES clocks after release
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      chain <= {STAGES{PBHH_REQ_RST}};
    else
      chain <= {chain[STAGES-2:0], async_i}; // RL1 RL18
  end

  assign sync_o = chain[STAGES-1];
endmodule
`default_nettype wire

// ==== src/pbhh_wbuf.sv ====
// one-entry store for every cpu write, posted whether the bus is owned or given away
// assumes pop is raised only while pend is high
`timescale 1ns/1ns
`default_nettype none
module pbhh_wbuf
  import pbhh_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  pbhh_wr_if.store  wr
);
  logic full;

  assign wr.push_ready = !full;
  assign wr.pend       = full;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      full <= 1'b0;
    else if (wr.push_valid && !full)
      full <= 1'b1; // RL7
    else if (wr.pop)
      full <= 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr.pend_addr <= '0;
      wr.pend_data <= '0;
    end
    else if (wr.push_valid && !full)
    begin
      wr.pend_addr <= wr.push_addr;
      wr.pend_data <= wr.push_data;
    end
  end
endmodule
`default_nettype wire

// ==== src/pbhh_top.sv ====
// primary bus owner with bus release handshake toward an external master
// assumes the cpu holds its request until acknowledged and the master obeys the grant
// Operation
// [RL1] release request is asynchronous and is synchronised before use
// [RL2] request sampled at phase-one falling edge; a late request costs one cycle
// [RL3] the ignore control beats the release request whatever its level
// [RL4] ignore set: leave any release, retake the bus, refuse later requests
// [RL5] no primary bus access while the release is granted
// [RL6] cpu keeps running during release, stalls only on a bus read or write
// [RL7] one write may be posted during release; a second write stalls
// [RL8] grant goes low in answer to the request going low
// [RL9] grant stays low until one phase-one cycle after request returns high
// [RL10] grant changes only on phase-one falling edges
// [RL11] strobe is driven high on a falling edge before it floats
// [RL12] strobe floats during release, timed from a falling edge
// [RL13] strobe is driven again on leaving release, from a falling edge
// [RL14] read-not-write floats during release and returns on a falling edge
// [RL15] address floats during release, timed from a falling edge
// [RL16] address driven valid again on leaving release, from a falling edge
// [RL17] data bus floats during release, timed from a rising edge
// [RL18] a request raised during device reset is honoured
// [RL19] master drives the bus only while granted and stops before releasing
// [RL20] master holds the request over at least one falling edge
`timescale 1ns/1ns
`default_nettype none
module pbhh_top
  import pbhh_pkg::*;
#(
  parameter int unsigned ADDR_W = PBHH_ADDR_W,
  parameter int unsigned DATA_W = PBHH_DATA_W
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              bus_release_req_n_i,
  input  wire logic              release_request_ignore_i,
  output logic                   bus_release_grant_n_o,
  output logic                   phase_one_clock_o,
  output logic                   access_strobe_n_o,
  output logic                   access_strobe_oe_o,
  output logic                   read_not_write_o,
  output logic                   read_not_write_oe_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic                   addr_oe_o,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe_o,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic              cpu_req_i,
  input  wire logic              cpu_we_i,
  input  wire logic [ADDR_W-1:0] cpu_addr_i,
  input  wire logic [DATA_W-1:0] cpu_wdata_i,
  output logic                   cpu_ack_o,
  output logic                   cpu_stall_o,
  output logic [DATA_W-1:0]      cpu_rdata_o
);
  initial
  begin
    if (ADDR_W < 1 || DATA_W < 1)
      $error("pbhh_top widths must be positive");
    if (PBHH_PHASE_HALF_CYC != 1)
      $error("pbhh_top supports a one-cycle phase half only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase-one clock and edge events

  logic        ph1;
  logic        fall_now;
  logic        rise_now;
  logic        req_sync_n;
  pbhh_state_t state;
  logic        drive;
  logic        acc_busy;
  logic        acc_write;
  logic        start_wr;
  logic        start_rd;
  logic        req_low;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ph1 <= PBHH_PHASE_RST;
    else
      ph1 <= !ph1;
  end

  assign phase_one_clock_o = ph1;
  // the edge closing this cycle is a falling (or rising) phase-one edge
  assign fall_now = ph1;
  assign rise_now = !ph1;

  pbhh_sync #(
    .STAGES (PBHH_SYNC_STAGES)
  ) u_req_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .async_i (bus_release_req_n_i),
    .sync_o  (req_sync_n)
  );

  // ignore overrides any request level
  assign req_low = !req_sync_n && !release_request_ignore_i; // RL3

  ////////////////////////////////////////////////////////////////////////////
  // release state, advanced only at falling edges

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= PBHH_ST_OWN;
    else if (fall_now) // RL2
    begin
      case (state)
        PBHH_ST_OWN:
          if (req_low)
            state <= PBHH_ST_QUIET; // RL8
        PBHH_ST_QUIET:
          if (release_request_ignore_i)
            state <= PBHH_ST_OWN; // RL4
          else
            state <= PBHH_ST_HELD;
        PBHH_ST_HELD:
          if (release_request_ignore_i)
            state <= PBHH_ST_OWN; // RL4
          else if (req_sync_n)
            state <= PBHH_ST_LEAVE; // RL9
        PBHH_ST_LEAVE:
          state <= PBHH_ST_OWN;
        default:
          state <= PBHH_ST_OWN;
      endcase
    end
  end

  // grant and pin drive follow the state at the same falling edges
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus_release_grant_n_o <= PBHH_GRANT_RST;
    else if (fall_now)
    begin
      if (state == PBHH_ST_QUIET && !release_request_ignore_i)
        bus_release_grant_n_o <= 1'b0; // RL8 RL10
      else if (state == PBHH_ST_LEAVE || release_request_ignore_i)
        bus_release_grant_n_o <= 1'b1; // RL9 RL4
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      drive <= PBHH_DRIVE_RST;
    else if (fall_now)
    begin
      if (state == PBHH_ST_QUIET && !release_request_ignore_i)
        drive <= 1'b0; // RL12 RL14 RL15
      else if (state == PBHH_ST_LEAVE || release_request_ignore_i)
        drive <= 1'b1; // RL13 RL14 RL16
    end
  end

  assign access_strobe_oe_o  = drive;
  assign read_not_write_oe_o = drive;
  assign addr_oe_o           = drive;

  ////////////////////////////////////////////////////////////////////////////
  // access engine: one phase-one cycle per access, only while owning

  pbhh_wr_if #(
    .AW (ADDR_W),
    .DW (DATA_W)
  ) wr ();

  pbhh_wbuf u_wbuf (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .wr      (wr)
  );

  // writes are posted into the store so the cpu runs on during release
  assign wr.push_valid = cpu_req_i && cpu_we_i; // RL6 RL7
  assign wr.push_addr  = cpu_addr_i;
  assign wr.push_data  = cpu_wdata_i;

  // no new access once a release is requested, and none while released
  assign start_wr = fall_now && state == PBHH_ST_OWN && !req_low && !acc_busy && wr.pend; // RL5
  assign start_rd = fall_now && state == PBHH_ST_OWN && !req_low && !acc_busy && !wr.pend
                    && cpu_req_i && !cpu_we_i; // RL5 RL6
  assign wr.pop   = fall_now && acc_busy && acc_write;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc_busy  <= 1'b0;
      acc_write <= 1'b0;
    end
    else if (start_wr || start_rd)
    begin
      acc_busy  <= 1'b1;
      acc_write <= start_wr;
    end
    else if (fall_now)
      acc_busy <= 1'b0;
  end

  // strobe returns high at the closing falling edge, so it is high before any float
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      access_strobe_n_o <= PBHH_STROBE_RST;
    else if (fall_now)
      access_strobe_n_o <= !(start_wr || start_rd); // RL11
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      read_not_write_o <= 1'b1;
      addr_o           <= '0;
      data_o           <= '0;
    end
    else if (start_wr)
    begin
      read_not_write_o <= 1'b0;
      addr_o           <= wr.pend_addr;
      data_o           <= wr.pend_data;
    end
    else if (start_rd)
    begin
      read_not_write_o <= 1'b1;
      addr_o           <= cpu_addr_i;
    end
  end

  // data pins follow the write access and are released at rising edges
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      data_oe_o <= 1'b0;
    else if (rise_now)
      data_oe_o <= drive && acc_busy && acc_write; // RL17
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cpu_rdata_o <= '0;
    else if (fall_now && acc_busy && !acc_write)
      cpu_rdata_o <= data_i;
  end

  // a write is acknowledged when the store takes it, a read when it completes
  assign cpu_ack_o   = (cpu_req_i && cpu_we_i && wr.push_ready)
                       || (cpu_req_i && !cpu_we_i && fall_now && acc_busy && !acc_write);
  assign cpu_stall_o = cpu_req_i && !cpu_ack_o; // RL6 RL7

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_leave_wait;
    !bus_release_grant_n_o ##1 !bus_release_grant_n_o ##1 bus_release_grant_n_o;
  endsequence

  sequence s_strobe_parked;
    access_strobe_oe_o && access_strobe_n_o;
  endsequence

  property p_grant_on_fall;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $changed(bus_release_grant_n_o) |-> !phase_one_clock_o;
  endproperty
  a_grant_on_fall: assert property (p_grant_on_fall) // RL10
    else $error("grant changed away from a falling edge");

  property p_release_exit;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (fall_now && state == PBHH_ST_HELD && req_sync_n && !release_request_ignore_i)
        |=> s_leave_wait;
  endproperty
  a_release_exit: assert property (p_release_exit) // RL9
    else $error("grant did not return one phase cycle after request");

  property p_ignore_retakes;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (fall_now && release_request_ignore_i) |=> bus_release_grant_n_o && drive;
  endproperty
  a_ignore_retakes: assert property (p_ignore_retakes) // RL4
    else $error("ignore did not end the release");

  property p_no_grant_when_ignored;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $fell(bus_release_grant_n_o) |-> !$past(release_request_ignore_i);
  endproperty
  a_no_grant_when_ignored: assert property (p_no_grant_when_ignored) // RL3
    else $error("grant given while ignore set");

  property p_no_access_released;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !bus_release_grant_n_o |-> !access_strobe_oe_o && !data_oe_o && !addr_oe_o;
  endproperty
  a_no_access_released: assert property (p_no_access_released) // RL5
    else $error("bus driven while released");

  property p_strobe_high_first;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $fell(access_strobe_oe_o) |-> $past(access_strobe_n_o, 1) && $past(access_strobe_n_o, 2);
  endproperty
  a_strobe_high_first: assert property (p_strobe_high_first) // RL11
    else $error("strobe floated without being parked high");

  property p_data_float_rise;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $fell(data_oe_o) |-> phase_one_clock_o;
  endproperty
  a_data_float_rise: assert property (p_data_float_rise) // RL17
    else $error("data released away from a rising edge");

  property p_grant_answers;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (fall_now && state == PBHH_ST_OWN && req_low)
        |-> ##[1:4] (!bus_release_grant_n_o || release_request_ignore_i);
  endproperty
  a_grant_answers: assert property (p_grant_answers) // RL8
    else $error("request not answered with grant");

  property p_pins_back;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(bus_release_grant_n_o) |-> s_strobe_parked and (read_not_write_oe_o && addr_oe_o);
  endproperty
  a_pins_back: assert property (p_pins_back) // RL13
    else $error("pins not driven again after release");

  property p_post_one_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (!bus_release_grant_n_o && cpu_req_i && cpu_we_i && !wr.pend) |-> cpu_ack_o ##1 wr.pend;
  endproperty
  a_post_one_write: assert property (p_post_one_write) // RL7
    else $error("first write during release not posted");

  property p_read_stalls;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (!bus_release_grant_n_o && cpu_req_i && !cpu_we_i) |-> cpu_stall_o;
  endproperty
  a_read_stalls: assert property (p_read_stalls) // RL6
    else $error("read not stalled during release");
endmodule
`default_nettype wire

// ==== tb/pbhh_bus_master.sv ====
// external master model: takes the primary bus on request and serves memory reads
// assumes the grant, strobe and enables come straight from pbhh_top
`timescale 1ns/1ns
`default_nettype none
module pbhh_bus_master
  import pbhh_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   grant_n_i,
  input  wire logic                   strobe_n_i,
  input  wire logic                   strobe_oe_i,
  input  wire logic                   rw_i,
  input  wire logic [PBHH_ADDR_W-1:0] addr_i,
  input  wire logic [PBHH_DATA_W-1:0] dev_data_i,
  input  wire logic                   dev_oe_i,
  output logic                        req_n_o,
  output logic [PBHH_DATA_W-1:0]      bus_o
);
  logic [PBHH_DATA_W-1:0]             mem [logic [PBHH_ADDR_W-1:0]];
  logic [PBHH_ADDR_W+PBHH_DATA_W-1:0] wr_q [$];
  logic [PBHH_DATA_W-1:0]             last = '0;
  logic                               drive = 1'b0;

  initial req_n_o = 1'b1;
  ////////////////////////////////
  // undriven data lines show a fresh pattern every cycle
  always @*
  begin
    if (dev_oe_i)
      bus_o = dev_data_i;
    else if (strobe_oe_i && !strobe_n_i && rw_i)
      bus_o = mem.exists(addr_i) ? mem[addr_i] : {8'h5A, addr_i};
    else if (drive && !grant_n_i)
      bus_o = 32'hC3C3_0F0F;
    else
      bus_o = ~last;
  end

  always @(posedge mclk_i)
    last <= bus_o;

  always @(negedge mclk_i)
    if (strobe_oe_i && !strobe_n_i && !rw_i && dev_oe_i)
    begin
      mem[addr_i] = dev_data_i;
      wr_q.push_back({addr_i, dev_data_i});
    end
  ////////////////////////////////
  // one release request, ofs ns into the cycle; up and dn count edges to the grant changes
  task automatic request(input int ofs, input int hold, output int up, output int dn);
    begin
      @(posedge mclk_i);
      #ofs req_n_o = 1'b0;
      up = 0;
      do
      begin
        @(posedge mclk_i);
        #1 up++;
      end while (grant_n_i !== 1'b0 && up < 40);
      drive = 1'b1;
      repeat (hold)
        @(posedge mclk_i);
      #5 drive = 1'b0;
      @(posedge mclk_i);
      #5 req_n_o = 1'b1;
      dn = 0;
      do
      begin
        @(posedge mclk_i);
        #1 dn++;
      end while (grant_n_i !== 1'b1 && dn < 40);
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_primary_bus_hold_handshake.sv ====
// self-checking bench for pbhh_top with an external master model
// assumes pbhh_bus_master and the design are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_primary_bus_hold_handshake
  import pbhh_pkg::*;
;
  localparam int DLY = 5;
  logic                   mclk_i, rst_n_i, req_n, ignore, grant_n, ph1, access_strobe_n_n, access_strobe_n_oe;
  logic                   rw, rw_oe, a_oe, d_oe, cpu_req, cpu_we, cpu_ack, cpu_stall, g;
  logic [PBHH_ADDR_W-1:0] addr, cpu_addr;
  logic [PBHH_DATA_W-1:0] dout, din, cpu_wdata, cpu_rdata;
  logic [PBHH_DATA_W-1:0] exp_mem [logic [PBHH_ADDR_W-1:0]];
  logic [55:0]            exp_q [$];
  logic [PBHH_ADDR_W-1:0] aq [$];
  logic [5:0]             prv = '0;
  logic [31:0]            seed = 32'h0FBB;
  logic [31:0]            r;
  int                     mismatches = 0, checks = 0, up, dn, n;
  int                     ofs [3] = '{5, 20, 40};

  pbhh_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_release_req_n_i(req_n),
    .release_request_ignore_i(ignore), .bus_release_grant_n_o(grant_n), .phase_one_clock_o(ph1),
    .access_strobe_n_o(access_strobe_n_n), .access_strobe_oe_o(access_strobe_n_oe), .read_not_write_o(rw),
    .read_not_write_oe_o(rw_oe), .addr_o(addr), .addr_oe_o(a_oe), .data_o(dout), .data_oe_o(d_oe),
    .data_i(din), .cpu_req_i(cpu_req), .cpu_we_i(cpu_we), .cpu_addr_i(cpu_addr),
    .cpu_wdata_i(cpu_wdata), .cpu_ack_o(cpu_ack), .cpu_stall_o(cpu_stall), .cpu_rdata_o(cpu_rdata));

  pbhh_bus_master m (.mclk_i(mclk_i), .grant_n_i(grant_n), .strobe_n_i(access_strobe_n_n), .strobe_oe_i(access_strobe_n_oe),
    .rw_i(rw), .addr_i(addr), .dev_data_i(dout), .dev_oe_i(d_oe), .req_n_o(req_n), .bus_o(din));
  ////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one cpu access; wt counts stalled cycles, gr is the grant seen at the ack
  task automatic cpu_op(input logic we, input logic [PBHH_ADDR_W-1:0] a, input logic [PBHH_DATA_W-1:0] d,
                        output int wt, output logic gr);
    logic [PBHH_DATA_W-1:0] e;
    e = exp_mem.exists(a) ? exp_mem[a] : {8'h5A, a};
    cpu_req = 1'b1;
    cpu_we = we;
    cpu_addr = a;
    cpu_wdata = d;
    wt = 0;
    @(negedge mclk_i);
    while (cpu_ack !== 1'b1 && wt < 400)
    begin
      chk("cpu stall", 1'b1, cpu_stall);
      @(negedge mclk_i);
      wt++;
    end
    gr = grant_n;
    chk("cpu ack", 1'b1, cpu_ack);
    chk("cpu stall at ack", 1'b0, cpu_stall);
    @(posedge mclk_i);
    #DLY cpu_req = 1'b0;
    if (we)
    begin
      exp_q.push_back({a, d});
      exp_mem[a] = d;
    end
    @(negedge mclk_i);
    if (!we)
      chk("read data", e, cpu_rdata);
    @(posedge mclk_i);
    #DLY;
  endtask
  ////////////////////////////////
  // pin relations watched on every settled cycle
  always @(negedge mclk_i)
  begin
    if (rst_n_i && prv[5])
    begin
      chk("phase toggles", !prv[3], ph1);
      if (grant_n !== prv[4])
        chk("grant edge phase", 1'b1, prv[3]);
      if (d_oe !== prv[2])
        chk("data enable edge phase", 1'b0, prv[3]);
      if (prv[1] && !access_strobe_n_oe)
        chk("strobe high before float", 1'b1, prv[0]);
      if (grant_n === 1'b0)
        chk("enables granted", 4'h0, {access_strobe_n_oe, rw_oe, a_oe, d_oe});
      else
        chk("enables owned", 3'h7, {access_strobe_n_oe, rw_oe, a_oe});
    end
    prv <= {rst_n_i, grant_n, ph1, d_oe, access_strobe_n_oe, access_strobe_n_n};
  end

  always @(posedge mclk_i)
    while (m.wr_q.size() > 0)
      chk("bus write", exp_q.size() ? exp_q.pop_front() : 56'h0, m.wr_q.pop_front());

  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  initial
  begin
    #(50 * 20000);
    mismatches++;
    complete_run;
  end

  initial
  begin
    rst_n_i = 1'b0;
    ignore = 1'b0;
    {cpu_req, cpu_we, cpu_addr, cpu_wdata} = '0;
    fork
      m.request(DLY, 6, up, dn);
      begin
        repeat (10) @(posedge mclk_i);
        #DLY rst_n_i = 1'b1;
      end
    join
    chk("request through reset", 1'b1, up < 40 && dn < 40);
    $display("test reset request done");
    foreach (ofs[i])
    begin
      m.request(ofs[i], 4 + 3 * i, up, dn);
      chk("grant latency", 1'b1, up >= 4 && up <= 7);
      chk("grant release", 1'b1, dn >= 4 && dn <= 7);
    end
    $display("test handshake done");
    fork
      m.request(DLY, 30, up, dn);
      begin
        wait (grant_n === 1'b0);
        @(posedge mclk_i);
        #DLY cpu_op(1'b1, 24'h00_0100, 32'h1234_5678, n, g);
        chk("posted write wait", 0, n);
        cpu_op(1'b1, 24'h00_0104, 32'h9ABC_DEF0, n, g);
        chk("second write grant", 1'b1, g);
      end
    join
    fork
      m.request(DLY, 20, up, dn);
      begin
        wait (grant_n === 1'b0);
        @(posedge mclk_i);
        #DLY cpu_op(1'b0, 24'h00_0100, '0, n, g);
        chk("read stalls grant", 1'b1, g);
      end
    join
    $display("test posted write done");
    fork
      m.request(DLY, 20, up, dn);
      begin
        wait (grant_n === 1'b0);
        @(posedge mclk_i);
        #DLY ignore = 1'b1;
        repeat (2) @(posedge mclk_i);
        #1 chk("ignore retakes bus", 1'b1, grant_n);
      end
    join
    m.request(DLY, 4, up, dn);
    chk("request refused", 40, up);
    @(posedge mclk_i);
    #DLY ignore = 1'b0;
    $display("test ignore done");
    fork
      m.request(DLY, 8, up, dn);
      repeat (6)
      begin
        r = xs();
        aq.push_back(r[PBHH_ADDR_W-1:0]);
        cpu_op(1'b1, r[PBHH_ADDR_W-1:0], xs(), n, g);
      end
    join
    foreach (aq[i])
      cpu_op(1'b0, aq[i], '0, n, g);
    cpu_op(1'b0, 24'h00_0ABC, '0, n, g);
    repeat (10) @(posedge mclk_i);
    chk("writes all seen", 0, exp_q.size());
    $display("test random traffic done");
    complete_run;
  end
endmodule
`default_nettype wire
